// *** multichannel_value_comparator.sv ***
// Top of the four channel 16-bit value comparator with sequencer and interrupt.
// Assumes all inputs synchronous to clock; configuration arrives on plain ports.
`timescale 1ns/1ps
module multichannel_value_comparator (
	// Clock and reset
	input  wire logic                                           clock,
	input  wire logic                                           rst_n,
	// Comparator control
	input  wire logic                                           cmp_reset,
	input  wire logic                                           enable,
	input  wire logic [1:0]                                     run_mode,
	input  wire logic [2:0]                                     ready_sel,
	// Data sources and ready levels
	input  wire value_cmp_pkg::sources_type                     sources,
	input  wire logic [3:0]                                     buffer_ready,
	input  wire logic                                           table_ready,
	// Channel configuration
	input  wire value_cmp_pkg::chan_cfg_type [3:0]              chan_cfg,
	// Register port
	input  wire logic [3:0]                                     reg_addr,
	input  wire logic [31:0]                                    reg_wdata,
	input  wire logic                                           reg_write,
	input  wire logic                                           reg_read,
	output logic      [31:0]                                    reg_rdata,
	// Results
	output logic      [3:0]                                     channel_result_outputs,
	output logic                                                data_ready,
	output wire logic                                           irq
);

	// ------------------------------------------------------------
	// Register offsets and event layout
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_STATUS  = 4'h0;
	localparam logic [3:0] OFS_CLEAR   = 4'h4;
	localparam logic [3:0] OFS_ENABLE  = 4'h8;
	localparam logic [3:0] OFS_RESULTS = 4'hC;
	localparam int         EV_DONE     = 0;
	localparam int         EV_RISE     = 1;
	localparam int         EV_FALL     = 2;

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_UPDATE = 3'b010,
		ST_DONE   = 3'b100
	} seq_state_type;

	seq_state_type seq_state_reg;
	seq_state_type seq_state_next;

	wire logic       start;
	wire logic       ready_level;
	wire logic [3:0] decided;

	// Ready source: buffer 0..3 or, on any other code, the table ready.
	assign ready_level = (ready_sel < 3'h4) ? buffer_ready[ready_sel[1:0]] : table_ready;

	value_cmp_trigger trigger_inst (
		.clock       (clock),
		.rst_n       (rst_n),
		.sync_clear  (cmp_reset),
		.run_mode    (run_mode),
		.enable      (enable),
		.ready_level (ready_level),
		.start       (start)
	);

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	// All four channels decide in parallel; the sequence latches them together.
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_chan
			value_cmp_channel chan_inst (
				.cfg     (chan_cfg[ch]),
				.src     (sources),
				.held    (channel_result_outputs[ch]),
				.decided (decided[ch])
			);
		end
	endgenerate

	// Next state: a start samples, then one cycle signals completion.
	always_comb begin
		seq_state_next = seq_state_reg;
		case (seq_state_reg)
			ST_IDLE:   seq_state_next = start ? ST_UPDATE : ST_IDLE;
			ST_UPDATE: seq_state_next = ST_DONE;
			ST_DONE:   seq_state_next = start ? ST_UPDATE : ST_IDLE;
			default:   seq_state_next = ST_IDLE;
		endcase
	end

	wire logic update_now;

	// Continuous mode stops as soon as enable drops, even mid pass.
	assign update_now = (seq_state_reg == ST_UPDATE) &&
		!((run_mode == value_cmp_pkg::RUN_CONTINUOUS) && !enable);

	// Sequencer and latched outputs; the reset input aborts everything.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_state_reg          <= ST_IDLE;
			channel_result_outputs <= 4'h0;
			data_ready             <= 1'b0;
		end else if (cmp_reset) begin
			seq_state_reg          <= ST_IDLE;
			channel_result_outputs <= 4'h0;
			data_ready             <= 1'b0;
		end else begin
			seq_state_reg <= seq_state_next;
			data_ready    <= update_now;
			if (update_now) begin
				channel_result_outputs <= decided;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, clear and enable
	// ------------------------------------------------------------
	logic [2:0] status_reg;
	logic [2:0] irq_enable_reg;
	logic [3:0] prev_out_reg;

	wire logic [2:0] events;
	wire logic       clear_hit;

	assign events[EV_DONE] = data_ready;
	assign events[EV_RISE] = |(channel_result_outputs & ~prev_out_reg);
	assign events[EV_FALL] = |(~channel_result_outputs & prev_out_reg);
	assign clear_hit       = reg_write && (reg_addr == OFS_CLEAR);

	// A fresh event wins over a clear arriving in the same cycle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_reg     <= 3'h0;
			irq_enable_reg <= 3'h0;
			prev_out_reg   <= 4'h0;
		end else begin
			prev_out_reg <= channel_result_outputs;
			status_reg   <= (status_reg & ~(clear_hit ? reg_wdata[2:0] : 3'h0)) | events;
			if (reg_write && (reg_addr == OFS_ENABLE)) begin
				irq_enable_reg <= reg_wdata[2:0];
			end
		end
	end

	assign irq = |(status_reg & irq_enable_reg);

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Clear register reads zero; unmapped offsets read zero.
	wire logic [31:0] read_mux;

	assign read_mux = (reg_addr == OFS_STATUS)  ? {29'h0, status_reg} :
		(reg_addr == OFS_ENABLE)  ? {29'h0, irq_enable_reg} :
		(reg_addr == OFS_RESULTS) ? {28'h0, channel_result_outputs} : 32'h0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_read ? read_mux : 32'h0;
		end
	end

endmodule : multichannel_value_comparator

// *** value_cmp_pkg.sv ***
// Shared constants and types for the multichannel value comparator.
// Assumes a single 50 MHz clock; channel configuration is on plain ports, not on the register port.
package value_cmp_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int DATA_W     = 16;
	localparam int SUM_W      = 17;
	localparam int CHANNELS   = 4;
	localparam int BUFFERS    = 4;

	// ------------------------------------------------------------
	// Source select encodings
	// ------------------------------------------------------------
	localparam logic [2:0] POS_TABLE  = 3'h0;
	localparam logic [2:0] POS_ARITH  = 3'h1;
	localparam logic [2:0] POS_BUF0   = 3'h2;
	localparam logic [2:0] POS_BUF1   = 3'h3;
	localparam logic [2:0] POS_BUF2   = 3'h4;
	localparam logic [2:0] POS_BUF3   = 3'h5;
	localparam logic [2:0] POS_FIXED  = 3'h6;

	localparam logic [2:0] NEG_BUF0   = 3'h0;
	localparam logic [2:0] NEG_FIXED  = 3'h4;

	// ------------------------------------------------------------
	// Operation modes
	// ------------------------------------------------------------
	localparam logic [1:0] RUN_CONTINUOUS = 2'h0;
	localparam logic [1:0] RUN_ON_ENABLE  = 2'h1;
	localparam logic [1:0] RUN_ON_READY   = 2'h2;

	localparam logic       HYST_REGULAR   = 1'h0;
	localparam logic       HYST_OFFSET    = 1'h1;

	// Per channel configuration carried as one bundle.
	typedef struct packed {
		logic [2:0]        pos_sel;
		logic [2:0]        neg_sel;
		logic              hyst_mode;
		logic              equal_test;
		logic [DATA_W-1:0] hysteresis;
		logic [DATA_W-1:0] pos_fixed;
		logic [DATA_W-1:0] neg_fixed;
	} chan_cfg_type;

	// Data sources presented to the comparator.
	typedef struct packed {
		logic [DATA_W-1:0]                table_out;
		logic [DATA_W-1:0]                arith_out;
		logic [BUFFERS-1:0][DATA_W-1:0]   buffer_out;
	} sources_type;

endpackage : value_cmp_pkg

// *** value_cmp_channel.sv ***
// One comparator channel: operand selection, 17-bit threshold and decision.
// Assumes operands are synchronous to the clock; the caller supplies the held output.
`timescale 1ns/1ps
module value_cmp_channel (
	// Configuration and data
	input  wire value_cmp_pkg::chan_cfg_type          cfg,
	input  wire value_cmp_pkg::sources_type           src,
	// Present output and decision
	input  wire logic                                 held,
	output wire logic                                 decided
);

	// ------------------------------------------------------------
	// Operand selection
	// ------------------------------------------------------------
	// Positive operand: table, arithmetic unit, buffer 0..3 or fixed.
	function automatic logic [15:0] pick_pos(input logic [2:0] sel,
		input value_cmp_pkg::sources_type s, input logic [15:0] fixed);
		case (sel)
			value_cmp_pkg::POS_TABLE: pick_pos = s.table_out;
			value_cmp_pkg::POS_ARITH: pick_pos = s.arith_out;
			value_cmp_pkg::POS_BUF0:  pick_pos = s.buffer_out[0];
			value_cmp_pkg::POS_BUF1:  pick_pos = s.buffer_out[1];
			value_cmp_pkg::POS_BUF2:  pick_pos = s.buffer_out[2];
			value_cmp_pkg::POS_BUF3:  pick_pos = s.buffer_out[3];
			default:                  pick_pos = fixed;
		endcase
	endfunction : pick_pos

	wire logic [15:0] pos_val;
	wire logic [15:0] neg_val;
	wire logic [16:0] threshold;
	wire logic        above;
	wire logic        at_or_below_neg;
	wire logic        equal_hit;

	assign pos_val = pick_pos(cfg.pos_sel, src, cfg.pos_fixed);
	assign neg_val = (cfg.neg_sel < value_cmp_pkg::NEG_FIXED)
		? src.buffer_out[cfg.neg_sel[1:0]] : cfg.neg_fixed;

	// ------------------------------------------------------------
	// Threshold and decision
	// ------------------------------------------------------------
	// The sum keeps its carry so a large hysteresis cannot wrap to a small threshold.
	assign threshold       = {1'b0, neg_val} + {1'b0, cfg.hysteresis};
	assign above           = {1'b0, pos_val} > threshold;
	assign at_or_below_neg = pos_val <= neg_val;
	assign equal_hit       = {1'b0, pos_val} == threshold;

	// Regular mode holds between the two thresholds; offset mode has one edge.
	assign decided = (cfg.hyst_mode == value_cmp_pkg::HYST_REGULAR)
		? (above ? 1'b1 : (at_or_below_neg ? 1'b0 : held))
		: (cfg.equal_test ? equal_hit : above);

endmodule : value_cmp_channel

// *** value_cmp_trigger.sv ***
// Start logic: turns enable and ready levels into start pulses per run mode.
// Assumes enable and ready inputs are synchronous levels.
`timescale 1ns/1ps
module value_cmp_trigger (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       sync_clear,
	// Control
	input  wire logic [1:0] run_mode,
	input  wire logic       enable,
	input  wire logic       ready_level,
	// Start request
	output wire logic       start
);

	logic enable_reg;
	logic ready_reg;

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	// Previous levels; cleared by the reset input so an edge is seen afresh.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= 1'b0;
			ready_reg  <= 1'b0;
		end else if (sync_clear) begin
			enable_reg <= 1'b0;
			ready_reg  <= 1'b0;
		end else begin
			enable_reg <= enable;
			ready_reg  <= ready_level;
		end
	end

	wire logic enable_rise;
	wire logic ready_rise;

	assign enable_rise = enable & ~enable_reg;
	assign ready_rise  = ready_level & ~ready_reg;

	// Continuous mode asks for a pass every cycle while enable stays high.
	assign start = (run_mode == value_cmp_pkg::RUN_CONTINUOUS) ? enable :
		(run_mode == value_cmp_pkg::RUN_ON_ENABLE) ? enable_rise :
		(run_mode == value_cmp_pkg::RUN_ON_READY) ? ready_rise : 1'b0;

endmodule : value_cmp_trigger

// *** value_cmp_checker.sv ***
// Concurrent checks on the ports of the four channel value comparator.
// Assumes one clock domain and an active low asynchronous reset.
`timescale 1ns/1ps
module value_cmp_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Control and ready levels
	input wire logic        cmp_reset,
	input wire logic        enable,
	input wire logic [1:0]  run_mode,
	input wire logic [2:0]  ready_sel,
	input wire logic [3:0]  buffer_ready,
	input wire logic        table_ready,
	// Observed outputs
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0]  channel_result_outputs,
	input wire logic        data_ready
);
	// Selected ready level, so that ready mode starts can be tied to their cause.
	wire logic sel_ready = ready_sel[2] ? table_ready : buffer_ready[ready_sel[1:0]];

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	reset_clear_a: assert property (cmp_reset |=> channel_result_outputs == 4'h0 && !data_ready)
		else $error("comparator reset left outputs set");
	pulse_once_a: assert property (data_ready |=> !data_ready)
		else $error("data ready longer than one cycle");
	outputs_hold_a: assert property (!data_ready && !$past(cmp_reset) |-> $stable(channel_result_outputs))
		else $error("outputs moved without an update");
	cont_stop_a: assert property (run_mode == 2'h0 && !enable |=> !data_ready)
		else $error("continuous pass without enable");
	cont_run_a: assert property ((run_mode == 2'h0 && enable && !cmp_reset) [*4] |-> data_ready || $past(data_ready))
		else $error("continuous passes stalled");
	edge_start_a: assert property (run_mode == 2'h1 && $rose(enable) && !cmp_reset ##1 !cmp_reset |=> data_ready)
		else $error("enable edge gave no pass");
	edge_only_a: assert property (run_mode == 2'h1 && data_ready |-> $past(enable, 2) && !$past(enable, 3))
		else $error("pass without an enable edge");
	ready_start_a: assert property (run_mode == 2'h2 && $rose(sel_ready) && !cmp_reset ##1 !cmp_reset |=> data_ready)
		else $error("ready edge gave no pass");
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule : value_cmp_checker

// *** value_cmp_sources_model.sv ***
// Model of the buffers, table and arithmetic unit that feed the comparator.
// Assumes the bench loads new values with a one cycle strobe.
`timescale 1ns/1ps
module value_cmp_sources_model (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// Load request
	input  wire logic                       load,
	input  wire value_cmp_pkg::sources_type load_val,
	input  wire logic [2:0]                 ridx,
	input  wire logic [3:0]                 rdelay,
	// Sources and ready levels
	output value_cmp_pkg::sources_type      sources,
	output logic [3:0]                      buffer_ready,
	output logic                            table_ready
);
	logic [3:0] wait_reg;
	logic       armed_reg;

	// New data drops every ready level, so each ready is a fresh rising edge.
	// The delay lets the model answer promptly or slowly.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sources <= '0;
			buffer_ready <= 4'h0;
			table_ready <= 1'b0;
			wait_reg <= 4'h0;
			armed_reg <= 1'b0;
		end else if (load) begin
			sources <= load_val;
			buffer_ready <= 4'h0;
			table_ready <= 1'b0;
			wait_reg <= rdelay;
			armed_reg <= 1'b1;
		end else if (armed_reg && wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
		end else if (armed_reg) begin
			buffer_ready <= ridx[2] ? 4'h0 : 4'h1 << ridx[1:0];
			table_ready <= ridx[2];
			armed_reg <= 1'b0;
		end
	end
endmodule : value_cmp_sources_model

// *** test_multichannel_value_comparator.sv ***
// Self-checking bench for the four channel value comparator.
// Assumes the package, design, checker and source model are compiled first.
`timescale 1ns/1ps
module test_multichannel_value_comparator;
	typedef struct packed {
		logic [2:0] p, n;
		logic m, e;
		logic [15:0] h, a, b;
		logic x;
	} row_type;
	// Rows: pos and neg select, offset mode, equal test, hysteresis, a, b, result.
	row_type rows [13] = '{'{3'h0,3'h4,1'h1,1'h0,16'h5,16'h10,16'hA,1'h1},
		'{3'h1,3'h4,1'h1,1'h0,16'h5,16'hF,16'hA,1'h0}, '{3'h2,3'h4,1'h0,1'h0,16'h5,16'hF,16'hA,1'h0},
		'{3'h3,3'h4,1'h0,1'h0,16'h5,16'h10,16'hA,1'h1}, '{3'h4,3'h4,1'h0,1'h0,16'h5,16'hB,16'hA,1'h1},
		'{3'h6,3'h4,1'h0,1'h0,16'h5,16'hA,16'hA,1'h0}, '{3'h0,3'h3,1'h1,1'h1,16'h5,16'hF,16'hA,1'h1},
		'{3'h0,3'h3,1'h1,1'h1,16'h5,16'h10,16'hA,1'h0},
		'{3'h0,3'h4,1'h1,1'h0,16'hFFFF,16'hFFFF,16'h2,1'h0},
		'{3'h0,3'h4,1'h1,1'h1,16'hFFFF,16'h0,16'h1,1'h0}, '{3'h0,3'h3,1'h0,1'h1,16'h0,16'h5,16'h3,1'h1},
		'{3'h5,3'h4,1'h1,1'h0,16'h0,16'h1,16'hA,1'h0},
		'{3'h7,3'h5,1'h1,1'h0,16'h0,16'hB,16'hA,1'h1}};
	logic clock, table_ready, data_ready, irq;
	logic rst_n = 1'b0, cmp_reset = 1'b0, enable = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic load = 1'b0;
	logic [1:0] run_mode = 2'h1;
	logic [2:0] ready_sel = 3'h0, ridx = 3'h4;
	logic [3:0] reg_addr = 4'h0, rdelay = 4'h0, buffer_ready, channel_result_outputs;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	value_cmp_pkg::sources_type sources, load_val = '0;
	value_cmp_pkg::chan_cfg_type [3:0] chan_cfg = '0;
	int failures = 0, compares = 0, seen;

	multichannel_value_comparator u_multichannel_value_comparator (.clock, .rst_n, .cmp_reset,
		.enable, .run_mode, .ready_sel, .sources, .buffer_ready, .table_ready, .chan_cfg,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .channel_result_outputs,
		.data_ready, .irq);
	value_cmp_sources_model u_value_cmp_sources_model (.clock, .rst_n, .load, .load_val, .ridx,
		.rdelay, .sources, .buffer_ready, .table_ready);

	// Clock of 20 ns.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
			failures++;
		end
	endtask : chk

	// Loads one row into all four channels and into the source model.
	task automatic setup(input row_type r);
		@(posedge clock);
		for (int c = 0; c < 4; c++)
			chan_cfg[c] <= '{r.p, r.n, r.m, r.e, r.h, r.a, r.b};
		load_val <= '{r.a, r.a, {r.b, r.a, r.a, r.a}};
		load <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
	endtask : setup

	// Bounded wait for a pass to finish; running out ends the run as a mismatch.
	task automatic wait_dr;
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			#1;
			if (data_ready === 1'b1)
				break;
		end
		if (i == 20) begin
			$display("[ERR] data_ready expected 1 seen 0");
			failures++;
			print_verdict;
		end
	endtask : wait_dr

	task automatic pass;
		@(posedge clock);
		enable <= 1'b1;
		wait_dr;
		@(posedge clock);
		enable <= 1'b0;
	endtask : pass

	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] ad, input logic [31:0] ex);
		@(posedge clock);
		reg_addr <= ad;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk("reg_rdata", ex, reg_rdata);
	endtask : rd

	// Counts data ready pulses over a few cycles; no pass is expected meanwhile.
	task automatic count_dr(input int n);
		seen = 0;
		repeat (n) begin
			@(posedge clock);
			#1;
			if (data_ready === 1'b1)
				seen++;
		end
	endtask : count_dr

	initial begin
		repeat (20) @(posedge clock);
		chk("reset outputs", 32'h0, {27'h0, data_ready, channel_result_outputs});
		rst_n <= 1'b1;
		rd(4'h8, 32'h0);
		foreach (rows[i]) begin
			setup(rows[i]);
			pass;
			chk("row", {4{rows[i].x}}, channel_result_outputs);
		end
		$display("rows done");
		@(posedge clock);
		enable <= 1'b1;
		wait_dr;
		count_dr(6);
		chk("passes while held", 32'h0, seen);
		@(posedge clock);
		enable <= 1'b0;
		$display("held enable done");
		rd(4'h0, 32'h7);
		wr(4'h4, 32'h7);
		rd(4'h0, 32'h0);
		wr(4'h8, 32'h1);
		chk("irq idle", 32'h0, irq);
		pass;
		#1;
		chk("irq raised", 32'h1, irq);
		wr(4'h8, 32'h0);
		chk("irq masked", 32'h0, irq);
		rd(4'h2, 32'h0);
		$display("registers done");
		@(posedge clock);
		run_mode <= 2'h0;
		enable <= 1'b1;
		setup(rows[0]);
		wait_dr;
		wait_dr;
		chk("continuous high", 32'hF, channel_result_outputs);
		setup(rows[1]);
		wait_dr;
		wait_dr;
		chk("continuous low", 32'h0, channel_result_outputs);
		@(posedge clock);
		enable <= 1'b0;
		setup(rows[0]);
		count_dr(4);
		chk("stopped", 32'h0, {seen[27:0], channel_result_outputs});
		$display("continuous done");
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			run_mode <= 2'h2;
			ready_sel <= 3'(k);
			ridx <= 3'(k);
			rdelay <= 4'(k);
			setup(rows[k % 2]);
			wait_dr;
			chk("ready start", {4{rows[k % 2].x}}, channel_result_outputs);
		end
		rd(4'hC, 32'hF);
		$display("ready mode done");
		// A reset on the update edge must win over the latch.
		@(posedge clock);
		run_mode <= 2'h1;
		enable <= 1'b1;
		@(posedge clock);
		cmp_reset <= 1'b1;
		enable <= 1'b0;
		@(posedge clock);
		cmp_reset <= 1'b0;
		count_dr(4);
		chk("aborted pass", 32'h0, {seen[27:0], channel_result_outputs});
		$display("abort done");
		// The spare run mode code must never start a pass, even with enable held.
		@(posedge clock);
		run_mode <= 2'h3;
		enable <= 1'b1;
		count_dr(4);
		chk("spare mode", 32'h0, seen);
		@(posedge clock);
		run_mode <= 2'h1;
		enable <= 1'b0;
		pass;
		#1;
		chk("late pass", 32'hF, channel_result_outputs);
		wr(4'h8, 32'h1);
		chk("irq before reset", 32'h1, irq);
		// A mid-run asynchronous reset clears results, status and mask at once.
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		#1;
		chk("async reset", 32'h0, {26'h0, irq, data_ready, channel_result_outputs});
		@(posedge clock);
		rst_n <= 1'b1;
		rd(4'h8, 32'h0);
		rd(4'h0, 32'h0);
		$display("late tests done");
		print_verdict;
	end
endmodule : test_multichannel_value_comparator

bind multichannel_value_comparator value_cmp_checker u_value_cmp_checker (.clock, .rst_n,
	.cmp_reset, .enable, .run_mode, .ready_sel, .buffer_ready, .table_ready, .reg_read,
	.reg_rdata, .channel_result_outputs, .data_ready);
